// >>> verilog/psl_pkg.sv
// Shared constants, types and decoding for the strap and LED configuration block.
// Assumes a single 100 MHz core clock and an AHB-Lite register bus.
package psl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clocking and timing.
  localparam int CORE_HZ = 100_000_000;
  localparam int REF_HZ = 25_000_000;
  localparam int REF_DIV = CORE_HZ / REF_HZ;
  localparam int FLASH_TIME_MS = 500;
  localparam int FLASH_TICKS = FLASH_TIME_MS * (REF_HZ / 1000);
  localparam int FLASH_W = 24;
  localparam int SETTLE_CYC = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses and field positions.
  localparam logic [31:0] CTRL_ADDR = 32'h00000000;
  localparam logic [31:0] STRAP_ADDR = 32'h00000004;
  localparam logic [31:0] STATUS_ADDR = 32'h00000008;
  localparam int CTRL_SRST_BIT = 0;
  localparam int ST_PD_BIT = 0;
  localparam int ST_FLASH_BIT = 1;
  localparam int ST_DONE_BIT = 2;
  localparam int ST_XOVER_BIT = 3;
  localparam int ST_RMII_BIT = 4;
  localparam int ST_SERIAL_BIT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Pin vector layout; the strap register uses the low STRAP_W bits.
  localparam int PIN_LED_LSB = 0;
  localparam int PIN_CLS = 3;
  localparam int PIN_COL = 4;
  localparam int PIN_RPTR = 5;
  localparam int PIN_PD = 6;
  localparam int PIN_XOVER = 7;
  localparam int PIN_SCHEME = 8;
  localparam int PIN_SERIAL = 9;
  localparam int PIN_W = 10;
  localparam int STRAP_W = 6;
  localparam logic [STRAP_W-1:0] STRAP_RST = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Mode strap codes, advertised abilities and pin-use masks.
  localparam logic [2:0] MODE_DUAL = 3'h0;
  localparam logic [2:0] MODE_FX_HDX = 3'h1;
  localparam logic [2:0] MODE_FX_FDX = 3'h2;
  localparam logic [2:0] MODE_T10_HDX = 3'h3;
  localparam logic [2:0] MODE_T10_FDX = 3'h4;
  localparam logic [2:0] MODE_T100_HDX = 3'h5;
  localparam logic [2:0] MODE_T100_FDX = 3'h6;
  localparam logic [2:0] MODE_AUTO = 3'h7;
  localparam logic [3:0] ADV_ALL = 4'hF;
  localparam logic [3:0] ADV_DUAL_HDX = 4'h5;
  localparam logic [3:0] USE_MII = 4'hF;
  localparam logic [3:0] USE_RMII = 4'h3;
  localparam logic [3:0] USE_SERIAL = 4'h1;

  typedef enum logic [1:0] {
    PSL_SETTLE = 2'b00,
    PSL_CAPTURE = 2'b01,
    PSL_FLASH = 2'b10,
    PSL_RUN = 2'b11
  } psl_state_e;

  typedef struct packed {
    logic an_en;
    logic dual;
    logic fiber;
    logic speed100;
    logic fdx;
    logic [3:0] adv;
  } psl_mode_s;

  // Turns the three mode strap bits into operating-mode fields.
  function automatic psl_mode_s psl_decode(input logic [2:0] code);
    psl_mode_s m;
    m = '0;
    unique case (code)
      MODE_DUAL: begin
        m.dual = 1'b1;
        m.adv = ADV_DUAL_HDX;
      end
      MODE_FX_HDX: begin
        m.fiber = 1'b1;
        m.speed100 = 1'b1;
      end
      MODE_FX_FDX: begin
        m.fiber = 1'b1;
        m.speed100 = 1'b1;
        m.fdx = 1'b1;
      end
      MODE_T10_HDX: m.speed100 = 1'b0;
      MODE_T10_FDX: m.fdx = 1'b1;
      MODE_T100_HDX: m.speed100 = 1'b1;
      MODE_T100_FDX: begin
        m.speed100 = 1'b1;
        m.fdx = 1'b1;
      end
      MODE_AUTO: begin
        m.an_en = 1'b1;
        m.adv = ADV_ALL;
      end
    endcase
    return m;
  endfunction

endpackage

// >>> verilog/psl_led_if.sv
// Bundle between the strap core and the LED function encoder.
// Assumes both ends run on the core clock carried inside.
`timescale 1ns/100ps
`default_nettype none
interface psl_led_if;
  logic clk;
  logic rst_b;
  logic scheme;
  logic link_up;
  logic speed_100;
  logic full_duplex;
  logic activity;
  logic collision;
  logic [2:0] on;

  modport enc (input clk, rst_b, scheme, link_up, speed_100, full_duplex, activity, collision, output on);
  modport core (output clk, rst_b, scheme, link_up, speed_100, full_duplex, activity, collision, input on);
endinterface
`default_nettype wire

// >>> verilog/psl_led_enc.sv
// LED function encoder: logical on/off per LED from link status and scheme.
// Assumes status inputs are already on the core clock; polarity is applied outside.
`timescale 1ns/100ps
`default_nettype none
module psl_led_enc (
  // LED bundle.
  psl_led_if.enc led_if
);
  import psl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Separate-LED scheme shows duplex, speed and link; combined scheme folds
  // speed into two link lamps and shows duplex or collision on the third.
  always_comb begin
    if (led_if.scheme) begin
      led_if.on[0] = led_if.full_duplex; // RL14
      led_if.on[1] = led_if.speed_100;
      led_if.on[2] = led_if.link_up & ~led_if.activity;
    end else begin
      led_if.on[0] = led_if.link_up & led_if.speed_100 & ~led_if.activity; // RL14
      led_if.on[1] = led_if.link_up & ~led_if.speed_100 & ~led_if.activity;
      led_if.on[2] = led_if.full_duplex | led_if.collision;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the scheme selection.
  scheme_sep_a: assert property (@(posedge led_if.clk) disable iff (!led_if.rst_b) // RL14
    led_if.scheme |-> (led_if.on[1] == led_if.speed_100) && (led_if.on[0] == led_if.full_duplex))
    else $error("separate LED scheme shows wrong speed or duplex");
  scheme_dual_a: assert property (@(posedge led_if.clk) disable iff (!led_if.rst_b) // RL14
    (!led_if.scheme && !led_if.link_up) |-> (led_if.on[1:0] == 2'h0))
    else $error("combined LED scheme lights a link lamp without link");

endmodule // psl_led_enc
`default_nettype wire

// >>> verilog/psl_strap_top.sv
// Strap capture, mode decode, LED drive and power-down control with an AHB-Lite slave.
// Assumes pins are asynchronous to core_clk_i and link status inputs are on core_clk_i.
//
// Overview of operation
// RL1: After reset the three mode straps, shared with the LED pins, are sampled and held in the mode register.
// RL2: Mode code 000 is dual-speed half duplex, 001/010 fiber 100 half/full, 011/100 10 half/full, 101/110 100 half/full.
// RL3: Mode code 111 enables auto-negotiation and advertises all abilities.
// RL4: While the power-down pin is high the block shuts its outputs off, keeps the bus alive and quiets the MII.
// RL5: Power-down is left only by a hardware reset or a soft reset with the power-down pin low.
// RL6: A status pin strapped low is driven as cable status, 1 meaning a cable is present.
// RL7: A status pin strapped high is driven as link status, 0 meaning link up.
// RL8: The crossover pin high disables automatic crossover, low enables it.
// RL9: After reset or a soft reset all LEDs are lit once for 500 ms.
// RL10: An LED pin strapped high is driven active low, strapped low active high.
// RL11: Each LED pin is read as a strap during reset and then driven as an LED.
// RL12: Reduced MII uses two data bits each way and no MII clocks, collision or carrier pins, on a 50 MHz reference.
// RL13: Seven-wire serial mode uses data bit 0 only and keeps clocks, enable, collision and carrier active.
// RL14: The LED scheme pin low selects the combined lamp scheme, high the separate lamps.
// RL15: The collision pin strap selects normal MII when low and reduced MII when high.
// RL16: Straps are taken after reset release and LED drivers stay off until then.
// RL17: The 500 ms flash is counted in ticks of a 25 MHz reference enable.
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`default_nettype none
module psl_strap_top #(
  parameter int unsigned FLASH_TICKS_P = psl_pkg::FLASH_TICKS
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // LED and status pins, shared with straps.
  input wire logic [2:0] led_pin_i,
  output logic [2:0] led_pin_o,
  output logic [2:0] led_pin_oe_o,
  input wire logic cls_pin_i,
  output logic cls_pin_o,
  output logic cls_pin_oe_o,
  // Strap and control pins.
  input wire logic col_strap_i,
  input wire logic repeater_node_strap_i,
  input wire logic power_down_input_i,
  input wire logic crossover_auto_disable_i,
  input wire logic led_scheme_select_i,
  input wire logic seven_wire_serial_mode_i,
  // Link status from the transceiver core.
  input wire logic link_up_i,
  input wire logic speed_100_i,
  input wire logic full_duplex_i,
  input wire logic activity_i,
  input wire logic collision_i,
  input wire logic cable_present_i,
  // Configuration outputs.
  output logic an_enable_o,
  output logic [3:0] advertise_o,
  output logic dual_speed_o,
  output logic fiber_mode_o,
  output logic force_100_o,
  output logic force_fdx_o,
  output logic crossover_auto_o,
  output logic rmii_mode_o,
  output logic serial_mode_o,
  output logic repeater_mode_o,
  output logic power_down_o,
  output logic [3:0] txd_used_o,
  output logic [3:0] rxd_used_o,
  output logic mii_ctl_used_o
);
  import psl_pkg::*;

  logic [PIN_W-1:0] pin_raw, sync1_q, pin_s;
  logic [1:0] div_q, div_d;
  logic ref_tick;
  psl_state_e st_q, st_d;
  logic [FLASH_W-1:0] cnt_q, cnt_d;
  logic [STRAP_W-1:0] strap_q, strap_d;
  logic pd_q, pd_d;
  logic wen_q, wen_d;
  logic [31:0] waddr_q, waddr_d, rdata_q, rdata_d;
  logic acc, srst, done, flashing, rmii, serial;
  psl_mode_s mode;
  logic [2:0] led_o_q, led_o_d, led_oe_q, led_oe_d;
  logic cls_o_q, cls_o_d, cls_oe_q, cls_oe_d;
  psl_mode_s cfg_q, cfg_d;
  logic xover_q, xover_d, rmii_q, rmii_d, ser_q, ser_d, rptr_q, rptr_d, pdo_q, pdo_d;
  logic [3:0] use_q, use_d;
  logic ctl_q, ctl_d;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser for every pin read by the core logic.
  assign pin_raw = {seven_wire_serial_mode_i, led_scheme_select_i, crossover_auto_disable_i,
                    power_down_input_i, repeater_node_strap_i, col_strap_i, cls_pin_i, led_pin_i}; // RL11

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= '0;
      pin_s <= '0;
    end else begin
      sync1_q <= pin_raw;
      pin_s <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider giving a one-cycle 25 MHz reference enable.
  assign ref_tick = (div_q == 2'(REF_DIV - 1)); // RL17

  always_comb begin
    div_d = ref_tick ? 2'h0 : div_q + 2'h1;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY, reads registered in the address phase.
  assign acc = hsel_i & hready_i & htrans_i[1];
  assign srst = wen_q && (waddr_q == CTRL_ADDR) && hwdata_i[CTRL_SRST_BIT];
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_q;

  always_comb begin
    wen_d = acc & hwrite_i;
    waddr_d = acc ? haddr_i : waddr_q;
    rdata_d = rdata_q;
    if (acc && !hwrite_i) begin
      rdata_d = 32'h00000000;
      if (haddr_i == STRAP_ADDR) begin
        rdata_d[STRAP_W-1:0] = strap_q;
      end else if (haddr_i == STATUS_ADDR) begin
        rdata_d[ST_PD_BIT] = pd_q;
        rdata_d[ST_FLASH_BIT] = flashing;
        rdata_d[ST_DONE_BIT] = done;
        rdata_d[ST_XOVER_BIT] = xover_q;
        rdata_d[ST_RMII_BIT] = rmii_q;
        rdata_d[ST_SERIAL_BIT] = ser_q;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wen_q <= 1'b0;
      waddr_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
    end else begin
      wen_q <= wen_d;
      waddr_q <= waddr_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: settle the synchroniser, take the straps, flash, then run.
  assign done = (st_q == PSL_FLASH) || (st_q == PSL_RUN);
  assign flashing = (st_q == PSL_FLASH);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    strap_d = strap_q;
    pd_d = pd_q;
    // A high pin holds power-down; only a hardware reset or a soft reset with the pin low clears it.
    if (pin_s[PIN_PD]) begin
      pd_d = 1'b1; // RL4
    end else if (srst) begin
      pd_d = 1'b0; // RL5
    end
    unique case (st_q)
      PSL_SETTLE: begin
        cnt_d = cnt_q + FLASH_W'(1);
        if (cnt_q == FLASH_W'(SETTLE_CYC - 1)) begin
          st_d = PSL_CAPTURE; // RL16
        end
      end
      PSL_CAPTURE: begin
        strap_d = pin_s[STRAP_W-1:0]; // RL1
        st_d = PSL_FLASH;
        cnt_d = FLASH_W'(FLASH_TICKS_P); // RL9
      end
      PSL_FLASH: begin
        if (ref_tick) begin
          cnt_d = cnt_q - FLASH_W'(1); // RL17
          if (cnt_q <= FLASH_W'(1)) begin
            st_d = PSL_RUN;
          end
        end
      end
      PSL_RUN: st_d = PSL_RUN;
    endcase
    // A soft reset restarts the flash without taking the straps again.
    if (srst && done) begin
      st_d = PSL_FLASH; // RL9
      cnt_d = FLASH_W'(FLASH_TICKS_P);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= PSL_SETTLE;
      cnt_q <= '0;
      strap_q <= STRAP_RST;
      pd_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      strap_q <= strap_d;
      pd_q <= pd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LED function encoder.
  psl_led_if led_if ();
  assign led_if.clk = core_clk_i;
  assign led_if.rst_b = rst_b_i;
  assign led_if.scheme = pin_s[PIN_SCHEME];
  assign led_if.link_up = link_up_i;
  assign led_if.speed_100 = speed_100_i;
  assign led_if.full_duplex = full_duplex_i;
  assign led_if.activity = activity_i;
  assign led_if.collision = collision_i;

  psl_led_enc u_led_enc (
    .led_if(led_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs: pin drive, mode fields and MII pin use.
  assign mode = psl_decode(strap_q[PIN_LED_LSB +: 3]); // RL2
  assign rmii = strap_q[PIN_COL]; // RL15
  assign serial = pin_s[PIN_SERIAL] & ~rmii;

  always_comb begin
    // Polarity is the strapped level: a high strap makes the lamp active low.
    led_o_d = (flashing ? 3'h7 : led_if.on) ^ strap_q[PIN_LED_LSB +: 3]; // RL10
    led_oe_d = {3{done & ~pd_q}}; // RL16
    cls_o_d = strap_q[PIN_CLS] ? ~link_up_i : cable_present_i; // RL6 RL7
    cls_oe_d = done & ~pd_q;
    cfg_d = done ? mode : '0; // RL3
    xover_d = ~pin_s[PIN_XOVER]; // RL8
    rmii_d = rmii;
    ser_d = serial;
    rptr_d = strap_q[PIN_RPTR];
    pdo_d = pd_q;
    if (pd_q) begin
      use_d = 4'h0; // RL4
      ctl_d = 1'b0;
    end else if (rmii) begin
      use_d = USE_RMII; // RL12
      ctl_d = 1'b0;
    end else if (serial) begin
      use_d = USE_SERIAL; // RL13
      ctl_d = 1'b1;
    end else begin
      use_d = USE_MII;
      ctl_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      led_o_q <= 3'h0;
      led_oe_q <= 3'h0;
      cls_o_q <= 1'b0;
      cls_oe_q <= 1'b0;
      cfg_q <= '0;
      xover_q <= 1'b0;
      rmii_q <= 1'b0;
      ser_q <= 1'b0;
      rptr_q <= 1'b0;
      pdo_q <= 1'b0;
      use_q <= 4'h0;
      ctl_q <= 1'b0;
    end else begin
      led_o_q <= led_o_d;
      led_oe_q <= led_oe_d;
      cls_o_q <= cls_o_d;
      cls_oe_q <= cls_oe_d;
      cfg_q <= cfg_d;
      xover_q <= xover_d;
      rmii_q <= rmii_d;
      ser_q <= ser_d;
      rptr_q <= rptr_d;
      pdo_q <= pdo_d;
      use_q <= use_d;
      ctl_q <= ctl_d;
    end
  end

  assign led_pin_o = led_o_q;
  assign led_pin_oe_o = led_oe_q;
  assign cls_pin_o = cls_o_q;
  assign cls_pin_oe_o = cls_oe_q;
  assign an_enable_o = cfg_q.an_en;
  assign advertise_o = cfg_q.adv;
  assign dual_speed_o = cfg_q.dual;
  assign fiber_mode_o = cfg_q.fiber;
  assign force_100_o = cfg_q.speed100;
  assign force_fdx_o = cfg_q.fdx;
  assign crossover_auto_o = xover_q;
  assign rmii_mode_o = rmii_q;
  assign serial_mode_o = ser_q;
  assign repeater_mode_o = rptr_q;
  assign power_down_o = pdo_q;
  assign txd_used_o = use_q;
  assign rxd_used_o = use_q;
  assign mii_ctl_used_o = ctl_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  strap_take_a: assert property (st_q == PSL_CAPTURE |=> strap_q == $past(pin_s[STRAP_W-1:0])) // RL1
    else $error("straps not taken from the synchronised pins");
  mode_t100f_a: assert property ((done && strap_q[2:0] == MODE_T100_FDX) // RL2
    |=> force_100_o && force_fdx_o && !fiber_mode_o && !an_enable_o)
    else $error("mode 110 not decoded as forced 100 full duplex");
  mode_auto_a: assert property ((done && strap_q[2:0] == MODE_AUTO) |=> an_enable_o && advertise_o == 4'hF) // RL3
    else $error("mode 111 does not enable auto-negotiation with all abilities");
  pd_quiet_a: assert property (pd_q |=> led_pin_oe_o == 3'h0 && !cls_pin_oe_o && txd_used_o == 4'h0) // RL4
    else $error("outputs active during power-down");
  pd_exit_a: assert property ($fell(pd_q) |-> $past(srst) && !$past(pin_s[PIN_PD])) // RL5
    else $error("power-down left without soft reset and low pin");
  cable_sts_a: assert property ((done && !pd_q && !strap_q[PIN_CLS]) |=> cls_pin_o == $past(cable_present_i)) // RL6
    else $error("cable status pin wrong");
  link_sts_a: assert property ((done && !pd_q && strap_q[PIN_CLS]) |=> cls_pin_o == !$past(link_up_i)) // RL7
    else $error("link status pin wrong");
  xover_sel_a: assert property (1'b1 |=> crossover_auto_o == !$past(pin_s[PIN_XOVER])) // RL8
    else $error("crossover enable does not follow its pin");
  flash_hold_a: assert property ((flashing && cnt_q > FLASH_W'(1)) |=> flashing) // RL9
    else $error("flash ended early");
  flash_end_a: assert property ((flashing && cnt_q == FLASH_W'(1) && ref_tick && !srst) |=> st_q == PSL_RUN) // RL9
    else $error("flash did not end on its last tick");
  led_pol_a: assert property (flashing |=> led_pin_o == ~$past(strap_q[2:0])) // RL10
    else $error("lit LED level does not oppose its strap");
  oe_off_a: assert property ((st_q == PSL_SETTLE || st_q == PSL_CAPTURE) |=> led_pin_oe_o == 3'h0) // RL16
    else $error("LED driven before straps are taken");
  rmii_use_a: assert property ((rmii && !pd_q) |=> txd_used_o == 4'h3 && !mii_ctl_used_o) // RL12
    else $error("reduced MII pin use wrong");
  tick_gap_a: assert property (ref_tick |=> !ref_tick [*3] ##1 ref_tick) // RL17
    else $error("reference enable not every fourth cycle");

endmodule // psl_strap_top
`default_nettype wire

// >>> bench/psl_board.sv
// Board model: strap pull resistors on the shared LED and status pins.
// Assumes the design drives a pin only while its enable is high.
`timescale 1ns/100ps
`default_nettype none
module psl_board (
  // Pull levels and design drive, bits 2:0 LEDs, bit 3 status pin.
  input wire logic [3:0] pull_i,
  input wire logic [3:0] drv_i,
  input wire logic [3:0] oe_i,
  // Resolved pin levels.
  output logic [3:0] pin_o
);
  // A released pin falls back to its pull resistor level.
  assign pin_o = (oe_i & drv_i) | (~oe_i & pull_i);
endmodule // psl_board
`default_nettype wire

// >>> bench/test_psl_strap_top.sv
// Self-checking bench for the strap, LED and power-down block.
// Assumes zero-wait AHB-Lite and a shortened flash of 5 reference ticks.
`timescale 1ns/100ps
`default_nettype none
module test_psl_strap_top;
  import psl_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [3:0] pull = 4'h0;
  logic [3:0] drv;
  logic [3:0] oe;
  logic [3:0] pin;
  logic col = 1'b0, rps = 1'b0, pd = 1'b0, xov = 1'b0, sch = 1'b1, ser = 1'b0;
  logic link = 1'b0, fdx = 1'b0, cable = 1'b0, spd = 1'b0;
  logic an, dual, fib, f100, ffdx, xa, rm, sm, rp, pdo, mc;
  logic [3:0] adv, txd, rxd;
  int fail_count = 0;
  int cmp_count = 0;

  // Free-running 100 MHz core clock.
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  psl_board u_psl_board (.pull_i(pull), .drv_i(drv), .oe_i(oe), .pin_o(pin));
  psl_strap_top #(.FLASH_TICKS_P(5)) u_psl_strap_top (
    .core_clk_i(clk), .rst_b_i(rst_b), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .led_pin_i(pin[2:0]), .led_pin_o(drv[2:0]),
    .led_pin_oe_o(oe[2:0]), .cls_pin_i(pin[3]), .cls_pin_o(drv[3]), .cls_pin_oe_o(oe[3]),
    .col_strap_i(col), .repeater_node_strap_i(rps), .power_down_input_i(pd),
    .crossover_auto_disable_i(xov), .led_scheme_select_i(sch), .seven_wire_serial_mode_i(ser),
    .link_up_i(link), .speed_100_i(spd), .full_duplex_i(fdx), .activity_i(1'b0),
    .collision_i(1'b0), .cable_present_i(cable), .an_enable_o(an), .advertise_o(adv),
    .dual_speed_o(dual), .fiber_mode_o(fib), .force_100_o(f100), .force_fdx_o(ffdx),
    .crossover_auto_o(xa), .rmii_mode_o(rm), .serial_mode_o(sm), .repeater_mode_o(rp),
    .power_down_o(pdo), .txd_used_o(txd), .rxd_used_o(rxd), .mii_ctl_used_o(mc));

  ////////////////////////////////////////////////////////////////////////////
  // One comparison; a mismatch is reported and counted at once.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Single AHB-Lite word transfer; waits on hready at both phases.
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk("bus response", 32'h0, {31'h0, hresp});
  endtask

  // Hardware reset with a given mode code on the strap pulls.
  task automatic boot(input logic [2:0] c);
    pull <= {c[0], c};
    col <= (c == 3'h5);
    ser <= (c == 3'h6);
    xov <= c[1];
    rps <= c[2];
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    chk("pin enables in reset", 32'h0, {28'h0, oe});
    rst_b <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Every mode code: decode, strap register, flash, pin use and status pin.
  task automatic t_modes();
    logic [2:0] c;
    logic [31:0] rd;
    int n;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      boot(c);
      n = 0;
      repeat (40) begin
        @(posedge clk);
        if (oe[2:0] === 3'h7 && pin[2:0] === ~c) n++;
      end
      // Five reference ticks span more than four and at most five tick periods of four cycles.
      chk("flash length", 32'h1, {31'h0, n >= 17 && n <= 20});
      chk("mode decode", {23'h0, c == 3'h7, c == 3'h7 ? 4'hF : (c == 3'h0 ? 4'h5 : 4'h0), c == 3'h0,
          c == 3'h1 || c == 3'h2, c == 3'h1 || c == 3'h2 || c == 3'h5 || c == 3'h6,
          c == 3'h2 || c == 3'h4 || c == 3'h6}, {23'h0, an, adv, dual, fib, f100, ffdx});
      ahb(1'b0, STRAP_ADDR, 32'h0, rd);
      chk("strap register", {26'h0, c[2], c == 3'h5, c[0], c}, rd);
      chk("pin use", {23'h0, c == 3'h6, c == 3'h5, c == 3'h5 ? 4'h3 : (c == 3'h6 ? 4'h1 : 4'hF), c != 3'h5,
          ~c[1], c[2]}, {23'h0, sm, rm, txd, mc, xa, rp});
      chk("rx pin use", {28'h0, txd}, {28'h0, rxd});
      for (int v = 1; v >= 0; v--) begin
        cable <= v[0];
        link <= v[0];
        repeat (3) @(posedge clk);
        chk("status pin", {30'h0, 1'b1, v[0] ^ c[0]}, {30'h0, oe[3], pin[3]});
      end
    end
    $display("test modes done");
  endtask

  // Power down holds through a soft reset and after the pin falls; a soft reset with the pin low ends it.
  task automatic t_pd();
    logic [31:0] rd;
    pd <= 1'b1;
    repeat (5) @(posedge clk);
    chk("power down outputs", 32'h1000, {19'h0, pdo, txd, rxd, 1'b0, oe[2:0]});
    ahb(1'b0, STATUS_ADDR, 32'h0, rd);
    chk("status power down", 32'h1, {31'h0, rd[ST_PD_BIT]});
    ahb(1'b1, CTRL_ADDR, 32'h1, rd);
    pd <= 1'b0;
    repeat (5) @(posedge clk);
    chk("power down held", 32'h1, {31'h0, pdo});
    ahb(1'b1, CTRL_ADDR, 32'h1, rd);
    repeat (4) @(posedge clk);
    chk("soft reset leaves", {25'h0, 1'b0, 3'h7, ~pull[2:0]}, {25'h0, pdo, oe[2:0], pin[2:0]});
    ahb(1'b1, 32'h00000010, 32'hFFFFFFFF, rd);
    ahb(1'b0, 32'h00000010, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    ahb(1'b0, CTRL_ADDR, 32'h0, rd);
    chk("control self clears", 32'h0, rd);
    $display("test power down done");
  endtask

  // LED scheme select: separate lamps versus combined lamps.
  task automatic t_scheme();
    repeat (30) @(posedge clk);
    fdx <= 1'b1;
    link <= 1'b0;
    sch <= 1'b1;
    repeat (6) @(posedge clk);
    chk("separate leds", {29'h0, 3'h1 ^ pull[2:0]}, {29'h0, pin[2:0]});
    sch <= 1'b0;
    repeat (6) @(posedge clk);
    chk("combined leds", {29'h0, 3'h4 ^ pull[2:0]}, {29'h0, pin[2:0]});
    spd <= 1'b1;
    link <= 1'b1;
    repeat (6) @(posedge clk);
    chk("combined speed leds", {29'h0, 3'h5 ^ pull[2:0]}, {29'h0, pin[2:0]});
    $display("test scheme done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    t_modes();
    t_pd();
    t_scheme();
    end_sim();
  end

  // Watchdog: the tests need about 500 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule // test_psl_strap_top
`default_nettype wire
